//--- rtl/aimms_top.sv
/*
 Analog input mux mode select: holds mode and channel, drives registered
 switch controls for the amplifier positive and negative inputs.
 Assumes mode and channel inputs are synchronous to mclk.
*/
`timescale 1ns/1ns
`include "aimms_params.svh"
module aimms_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cfg_load,
   input wire logic [`AIMMS_MODE_W-1:0] cfg_mode,
   input wire logic [`AIMMS_CH_W-1:0] cfg_chan,
   output aimms_pkg::aimms_mode_type mode_q,
   output logic [`AIMMS_CH_W-1:0] chan_q,
   output logic [`AIMMS_NUM_CH-1:0] pos_sw_q,
   output logic [`AIMMS_NUM_CH-1:0] neg_sw_q,
   output logic neg_gnd_sw_q,
   output logic neg_sense_sw_q
);
   import aimms_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // Configuration hold
   logic mode_ok;
   assign mode_ok = (cfg_mode == `AIMMS_MODE_GROUNDED) ||
                    (cfg_mode == `AIMMS_MODE_FLOATING) ||
                    (cfg_mode == `AIMMS_MODE_PAIRED_DIFFERENTIAL_MODE);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= grounded_single_ended_mode;
      end else if (cfg_load && mode_ok) begin
         mode_q <= aimms_mode_type'(cfg_mode);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         chan_q <= '0;
      end else if (cfg_load) begin
         chan_q <= cfg_chan;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Switch decode, registered
   logic [`AIMMS_NUM_CH-1:0] pos_sw_d;
   logic [`AIMMS_NUM_CH-1:0] neg_sw_d;
   logic neg_gnd_sw_d;
   logic neg_sense_sw_d;

   aimms_decode u_dec (
      .mode(mode_q),
      .chan_sel(chan_q),
      .pos_sw(pos_sw_d),
      .neg_sw(neg_sw_d),
      .neg_gnd_sw(neg_gnd_sw_d),
      .neg_sense_sw(neg_sense_sw_d)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pos_sw_q <= `AIMMS_NUM_CH'h01;
      end else begin
         pos_sw_q <= pos_sw_d;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         neg_sw_q <= '0;
      end else begin
         neg_sw_q <= neg_sw_d;
      end
   end

   // Ground and sense never both closed
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         neg_gnd_sw_q <= 1'b1;
         neg_sense_sw_q <= 1'b0;
      end else begin
         neg_gnd_sw_q <= neg_gnd_sw_d;
         neg_sense_sw_q <= neg_sense_sw_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Named steps shared by the checks
   sequence seq_take_grounded;
      cfg_load && cfg_mode == `AIMMS_MODE_GROUNDED;
   endsequence

   sequence seq_take_floating;
      cfg_load && cfg_mode == `AIMMS_MODE_FLOATING;
   endsequence

   sequence seq_take_paired_differential_mode;
      cfg_load && cfg_mode == `AIMMS_MODE_PAIRED_DIFFERENTIAL_MODE;
   endsequence

   sequence seq_take_illegal;
      cfg_load && cfg_mode > `AIMMS_MODE_PAIRED_DIFFERENTIAL_MODE;
   endsequence

   sequence seq_gnd_pattern;
      neg_gnd_sw_q && !neg_sense_sw_q && neg_sw_q == '0 &&
      $onehot(pos_sw_q);
   endsequence

   sequence seq_float_pattern;
      neg_sense_sw_q && !neg_gnd_sw_q && neg_sw_q == '0 &&
      $onehot(pos_sw_q);
   endsequence

   sequence seq_paired_differential_mode_pattern;
      !neg_gnd_sw_q && !neg_sense_sw_q && $onehot(pos_sw_q) &&
      $onehot(neg_sw_q);
   endsequence

   sequence seq_pair_held;
      mode_q == paired_differential_mode ##1
      mode_q == paired_differential_mode &&
      $stable(chan_q[`AIMMS_PAIR_W-1:0]);
   endsequence

   ////////////////////////////////////////////////////////////////////
   // Checks
   AST_LEGAL_MODE: assert property (@(posedge mclk) disable iff (rst)
      mode_q inside {grounded_single_ended_mode,
                     floating_single_ended_mode,
                     paired_differential_mode})
      else $error("illegal input mode held");

   AST_GND_SEL: assert property (@(posedge mclk) disable iff (rst)
      mode_q == grounded_single_ended_mode |=>
      neg_gnd_sw_q && !neg_sense_sw_q && neg_sw_q == '0 &&
      pos_sw_q == (`AIMMS_NUM_CH'h01 << $past(chan_q)))
      else $error("grounded mode switch pattern wrong");

   AST_FLOAT_NOGND: assert property (@(posedge mclk) disable iff (rst)
      mode_q == floating_single_ended_mode |=>
      neg_sense_sw_q && !neg_gnd_sw_q && neg_sw_q == '0)
      else $error("floating mode touches ground");

   AST_SE_ONEHOT: assert property (@(posedge mclk) disable iff (rst)
      mode_q != paired_differential_mode |=> $onehot(pos_sw_q))
      else $error("single-ended positive not one channel");

   AST_PAIRED_DIFFERENTIAL_MODE_POS: assert property (@(posedge mclk) disable iff (rst)
      mode_q == paired_differential_mode |=>
      pos_sw_q == (`AIMMS_NUM_CH'h01 << {$past(chan_q[1:0]), 1'b0}))
      else $error("paired_differential_mode positive not even channel");

   AST_PAIRED_DIFFERENTIAL_MODE_NEG: assert property (@(posedge mclk) disable iff (rst)
      mode_q == paired_differential_mode |=>
      neg_sw_q == (`AIMMS_NUM_CH'h02 << {$past(chan_q[1:0]), 1'b0}) &&
      !neg_gnd_sw_q && !neg_sense_sw_q)
      else $error("paired_differential_mode negative not odd channel");

   AST_PAIRED_DIFFERENTIAL_MODE_IGNHI: assert property (@(posedge mclk) disable iff (rst)
      seq_pair_held |=> $stable(pos_sw_q) && $stable(neg_sw_q))
      else $error("paired_differential_mode upper selector bit changed switches");

   AST_RESET_MODE: assert property (@(posedge mclk)
      $fell(rst) |-> mode_q == grounded_single_ended_mode && neg_gnd_sw_q)
      else $error("reset did not select grounded mode");

   AST_GND_LOAD: assert property (@(posedge mclk) disable iff (rst)
      seq_take_grounded |=> mode_q == grounded_single_ended_mode ##1
      seq_gnd_pattern ##0
      pos_sw_q == (`AIMMS_NUM_CH'h01 << $past(cfg_chan, 2)))
      else $error("grounded load did not reach switches");

   AST_FLOAT_LOAD: assert property (@(posedge mclk) disable iff (rst)
      seq_take_floating |=> mode_q == floating_single_ended_mode ##1
      seq_float_pattern ##0
      pos_sw_q == (`AIMMS_NUM_CH'h01 << $past(cfg_chan, 2)))
      else $error("floating load did not reach switches");

   AST_PAIRED_DIFFERENTIAL_MODE_LOAD: assert property (@(posedge mclk) disable iff (rst)
      seq_take_paired_differential_mode |=> mode_q == paired_differential_mode ##1
      seq_paired_differential_mode_pattern ##0
      pos_sw_q == (`AIMMS_NUM_CH'h01 <<
                   {$past(cfg_chan[`AIMMS_PAIR_W-1:0], 2), 1'b0}))
      else $error("paired_differential_mode load did not reach switches");

   AST_BAD_MODE: assert property (@(posedge mclk) disable iff (rst)
      seq_take_illegal |=> $stable(mode_q) && chan_q == $past(cfg_chan))
      else $error("illegal mode load changed the mode");

   AST_CHAN_LOAD: assert property (@(posedge mclk) disable iff (rst)
      cfg_load |=> chan_q == $past(cfg_chan))
      else $error("channel not taken on load");

   AST_IDLE_HOLD: assert property (@(posedge mclk) disable iff (rst)
      !cfg_load |=> $stable(mode_q) && $stable(chan_q))
      else $error("selection changed without a load");

   AST_NEG_ONE: assert property (@(posedge mclk) disable iff (rst)
      $onehot({neg_sw_q, neg_gnd_sw_q, neg_sense_sw_q}))
      else $error("negative input not on exactly one path");

   AST_RESET_SW: assert property (@(posedge mclk)
      $fell(rst) |-> pos_sw_q == `AIMMS_NUM_CH'h01 && neg_sw_q == '0 &&
      !neg_sense_sw_q)
      else $error("reset did not park the switches");

   ////////////////////////////////////////////////////////////////////
   // Per-channel switch checks
   for (genvar ch = 0; ch < `AIMMS_NUM_CH; ch++) begin : g_ch_chk
      AST_CH_POS: assert property (@(posedge mclk) disable iff (rst)
         mode_q != paired_differential_mode |=>
         pos_sw_q[ch] == ($past(chan_q) == `AIMMS_CH_W'(ch)))
         else $error("single-ended channel switch wrong");
      if (ch % 2 == 0) begin : g_even
         AST_CH_EVEN: assert property (@(posedge mclk)
            disable iff (rst) neg_sw_q[ch] == 1'b0)
            else $error("even channel on negative input");
      end else begin : g_odd
         AST_CH_ODD: assert property (@(posedge mclk)
            disable iff (rst)
            mode_q == paired_differential_mode |=> pos_sw_q[ch] == 1'b0)
            else $error("odd channel on positive input");
      end
   end
endmodule : aimms_top

//--- rtl/aimms_params.svh
/*
 Constants for the analog input mux mode select block.
 Assumes inclusion by the package and modules of this block only.
*/
`ifndef AIMMS_PARAMS_SVH
`define AIMMS_PARAMS_SVH
`define AIMMS_NUM_CH 8
`define AIMMS_CH_W 3
`define AIMMS_PAIR_W 2
`define AIMMS_MODE_W 2
`define AIMMS_MODE_GROUNDED 2'h0
`define AIMMS_MODE_FLOATING 2'h1
`define AIMMS_MODE_PAIRED_DIFFERENTIAL_MODE 2'h2
`endif

//--- rtl/aimms_pkg.sv
/*
 Types for the analog input mux mode select block.
 Assumes aimms_params.svh is on the include path.
*/
`include "aimms_params.svh"
package aimms_pkg;
   typedef enum logic [`AIMMS_MODE_W-1:0] {
      grounded_single_ended_mode = `AIMMS_MODE_GROUNDED,
      floating_single_ended_mode = `AIMMS_MODE_FLOATING,
      paired_differential_mode = `AIMMS_MODE_PAIRED_DIFFERENTIAL_MODE
   } aimms_mode_type;
endpackage : aimms_pkg

//--- rtl/aimms_decode.sv
/*
 Combinational switch decoder: mode and channel to switch controls.
 Assumes its outputs are registered by the instantiating module.
*/
`timescale 1ns/1ns
`include "aimms_params.svh"
module aimms_decode (
   input wire aimms_pkg::aimms_mode_type mode,
   input wire logic [`AIMMS_CH_W-1:0] chan_sel,
   output logic [`AIMMS_NUM_CH-1:0] pos_sw,
   output logic [`AIMMS_NUM_CH-1:0] neg_sw,
   output logic neg_gnd_sw,
   output logic neg_sense_sw
);
   import aimms_pkg::*;
   logic [`AIMMS_PAIR_W-1:0] pair;
   assign pair = chan_sel[`AIMMS_PAIR_W-1:0];

   always_comb begin
      pos_sw = '0;
      neg_sw = '0;
      neg_gnd_sw = 1'b0;
      neg_sense_sw = 1'b0;
      unique case (mode)
         grounded_single_ended_mode: begin
            pos_sw[chan_sel] = 1'b1;
            neg_gnd_sw = 1'b1;
         end
         floating_single_ended_mode: begin
            pos_sw[chan_sel] = 1'b1;
            neg_sense_sw = 1'b1;
         end
         paired_differential_mode: begin
            pos_sw[{pair, 1'b0}] = 1'b1;
            neg_sw[{pair, 1'b1}] = 1'b1;
         end
         default: begin
            neg_gnd_sw = 1'b1;
         end
      endcase
   end
endmodule : aimms_decode

//--- test/aimms_afe_model.sv
/*
 Front end model: turns switch controls into amp input connections.
 Assumes one-hot switch controls from aimms_top.
*/
`timescale 1ns/1ns
module aimms_afe_model (
   input wire logic [7:0] pos_sw,
   input wire logic [7:0] neg_sw,
   input wire logic gnd_sw,
   input wire logic sense_sw,
   output logic [3:0] pos_ch,
   output logic [3:0] neg_ch
);
   // Channel index; 8 ground, 9 sense, f open or shorted
   always_comb begin
      pos_ch = 4'hf;
      neg_ch = 4'hf;
      for (int i = 0; i < 8; i++) begin
         if (pos_sw == (8'h01 << i))
            pos_ch = i[3:0];
         if (neg_sw == (8'h01 << i) && !gnd_sw && !sense_sw)
            neg_ch = i[3:0];
      end
      if (neg_sw == 8'h00 && gnd_sw && !sense_sw)
         neg_ch = 4'h8;
      if (neg_sw == 8'h00 && !gnd_sw && sense_sw)
         neg_ch = 4'h9;
   end
endmodule : aimms_afe_model

//--- test/aimms_top_test.sv
/*
 Self-checking bench for aimms_top with front end model.
 Assumes two-edge load latency to the switch outputs.
*/
`timescale 1ns/1ns
module aimms_top_test;
   logic mclk = 0, rst = 1, cfg_load = 0;
   logic [1:0] cfg_mode = 2'h0;
   logic [2:0] cfg_chan = 3'h0;
   aimms_pkg::aimms_mode_type mode_q;
   logic [2:0] chan_q;
   logic [7:0] pos_sw_q, neg_sw_q;
   logic neg_gnd_sw_q, neg_sense_sw_q;
   logic [3:0] pos_ch, neg_ch;
   int bad_count = 0, n_tests = 0;
   always #10 mclk = ~mclk;
   aimms_top u_dut (.mclk(mclk), .rst(rst), .cfg_load(cfg_load),
      .cfg_mode(cfg_mode), .cfg_chan(cfg_chan), .mode_q(mode_q),
      .chan_q(chan_q), .pos_sw_q(pos_sw_q), .neg_sw_q(neg_sw_q),
      .neg_gnd_sw_q(neg_gnd_sw_q), .neg_sense_sw_q(neg_sense_sw_q));
   aimms_afe_model u_afe (.pos_sw(pos_sw_q), .neg_sw(neg_sw_q),
      .gnd_sw(neg_gnd_sw_q), .sense_sw(neg_sense_sw_q),
      .pos_ch(pos_ch), .neg_ch(neg_ch));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic load(input logic [1:0] m, input logic [2:0] c);
      @(posedge mclk);
      cfg_load <= 1'b1;
      cfg_mode <= m;
      cfg_chan <= c;
      @(posedge mclk);
      cfg_load <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : load
   ////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      check({2'h0, mode_q}, 4'h0);
      check({1'b0, chan_q}, 4'h0);
      check(pos_ch, 4'h0);
      check(neg_ch, 4'h8);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_single;
      for (int c = 0; c < 8; c++) begin
         load(2'h0, c[2:0]);
         check(pos_ch, c[3:0]);
         check(neg_ch, 4'h8);
         load(2'h1, c[2:0]);
         check(pos_ch, c[3:0]);
         check(neg_ch, 4'h9);
      end
      $display("test_single done");
   endtask : test_single
   task automatic test_paired_differential_mode;
      for (int p = 0; p < 4; p++) begin
         load(2'h2, {p[0], 2'(p)});
         check(pos_ch, 4'(2 * p));
         check(neg_ch, 4'(2 * p + 1));
      end
      load(2'h2, 3'h3);
      check(pos_ch, 4'h6);
      check(neg_ch, 4'h7);
      $display("test_paired_differential_mode done");
   endtask : test_paired_differential_mode
   task automatic test_illegal;
      load(2'h1, 3'h3);
      load(2'h3, 3'h5);
      check({2'h0, mode_q}, 4'h1);
      check({1'b0, chan_q}, 4'h5);
      check(pos_ch, 4'h5);
      check(neg_ch, 4'h9);
      $display("test_illegal done");
   endtask : test_illegal
   ////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      #100000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      #1;
      test_reset();
      test_single();
      test_paired_differential_mode();
      test_illegal();
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1;
      test_reset();
      complete_run();
   end
endmodule : aimms_top_test
